// file: bench/indicator_viewer.sv
`timescale 1ns/1ps
// Operator view: every change of the red element is counted to judge its flash rate.
module indicator_viewer (
  input wire logic aclk, // System clock.
  input wire logic led_red, // Red element as seen.
  output logic [15:0] red_edges // Changes seen so far.
);
  logic last_r = 1'b0;
  logic [15:0] edge_cnt = 16'h0000;
  assign red_edges = edge_cnt;
  // Counting edges, not timing them, keeps slow and fast flashing apart.
  always @(posedge aclk) begin
    if (led_red !== last_r) edge_cnt <= edge_cnt + 16'h0001;
    last_r <= led_red;
  end
endmodule : indicator_viewer

// file: bench/receiver_status_indicator_control_tb.sv
`timescale 1ns/1ps
module receiver_status_indicator_control_tb;
  import indicator_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, led_red, led_green, led_yellow, led_blue;
  logic automatic_error_recovery, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rnd, rd_d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, wr_r, rd_r;
  logic [6:0] seg;
  logic [15:0] red_edges, e0;
  int failures, samples_checked, recov_seen;
  indicator_ctrl #(.TICK_CYC(4)) indicator_ctrl_i (.aclk, .aresetn, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .led_red, .led_green,
    .led_yellow, .led_blue, .seg, .automatic_error_recovery, .irq);
  indicator_viewer indicator_viewer_i (.aclk, .led_red, .red_edges);
  // The recovery pulse stands one cycle only, so every edge is watched.
  always @(posedge aclk) if (automatic_error_recovery === 1'b1) recov_seen++;
  // The clock toggles every half period of 10 ns.
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [6:0] digit(input logic [2:0] m);
    return (m == 3'h1) ? SEG_1 : (m == 3'h2) ? SEG_2 : SEG_3;
  endfunction : digit
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Each channel is released only at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    wr_r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd_d = rdata;
    rd_r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic conclude();
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // A run needs about 68600 cycles, most of it the ten second recovery wait.
  initial begin
    #(90000 * 20);
    failures++;
    conclude();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = {16'h0000, 32'h0, 4'hf};
    rnd = 32'h6bd7;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("boot digit", SEG_8, seg);
    rd(OFS_MODE);
    chk("mode reset", 32'h1, rd_d);
    rd(OFS_INDIC);
    chk("align at start", 1'b1, rd_d[1]);
    rd(8'h3c);
    chk("unmapped resp", 2'b10, rd_r);
    wr(OFS_STATE, 32'h1011);
    chk("write resp", 2'b00, wr_r);
    repeat (3) @(posedge aclk);
    chk("green", 2'b01, {led_red, led_green});
    wr(OFS_STATE, 32'h10bd);
    repeat (3) @(posedge aclk);
    chk("yellow blue", 2'b11, {led_yellow, led_blue});
    rnd = lfsr(lfsr(rnd));
    wr(OFS_MODE, 32'(rnd % 3) + 32'h1);
    repeat (24000) @(posedge aclk);
    chk("mode digit", digit(3'(rnd % 3 + 1)), seg);
    wr(OFS_INT_MASK, 32'h8);
    wr(OFS_ERROR, 32'h422);
    e0 = red_edges;
    repeat (3) @(posedge aclk);
    chk("irq raised", 1'b1, irq);
    chk("class letter", SEG_E, seg);
    repeat (4000) @(posedge aclk);
    chk("slow red", 1'b1, (red_edges - e0) inside {[1:4]});
    wr(OFS_INT_STAT, 32'h8);
    @(posedge aclk);
    chk("irq cleared", 1'b0, irq);
    wr(OFS_ERROR, 32'h171);
    e0 = red_edges;
    repeat (4000) @(posedge aclk);
    chk("fast red", 1'b1, (red_edges - e0) >= 16'd15);
    chk("early recovery", 0, recov_seen);
    repeat (36500) @(posedge aclk);
    chk("recovery pulse", 1, recov_seen);
    rd(OFS_ERROR);
    chk("error cleared", 32'h0, rd_d);
    wr(OFS_MODE, 32'h6);
    repeat (3) @(posedge aclk);
    // A six turned half way round lights g f d c b a.
    chk("rotated digit", 7'h6f, seg);
    wr(OFS_STATE, 32'h10ad);
    repeat (3) @(posedge aclk);
    chk("yellow field cut", 1'b0, led_yellow);
    wr(OFS_ERROR, 32'h1231);
    wr(OFS_ERROR, 32'h0);
    rd(OFS_ERROR);
    chk("blocking kept", 32'h1231, rd_d);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_ERROR);
    chk("error after reset", 32'h0, rd_d);
    conclude();
  end
endmodule : receiver_status_indicator_control_tb

// file: hdl/indicator_ctrl.sv
`timescale 1ns/1ps
// Contract
// - Status LED dark unpowered, red while outputs off, red 1 Hz on external error.
// - Internal error flashes the status LED red at 10 Hz.
// - Outputs on: solid green, or green 1 Hz when the signal is weak.
// - Yellow lit when interlock locked, field clear and linked sensor enabled.
// - Yellow dark when interlock off, released, or locked with field interrupted.
// - Yellow flashes while upstream circuit open; one or two flashes on changeover.
// - Blue dark with no special function, lit once blanking is taught.
// - Blue slow flash when muting; short flash for teach, muting restart, override.
// - Display shows the operating mode number one to six in normal operation.
// - Display rotated half a turn in modes four and six.
// - After power-up show eight, then t and two response time digits.
// - Errors show class letter F, E or U then the code, cyclically.
// - Non-locking errors recover automatically after ten seconds, never releasing outputs.
// - A blocking error stays locked until power is removed.
// - Alignment mode five seconds after field interruption or while unaligned.
// - Top, middle and bottom segments stand for upper, middle, lower beam thirds.
// - Segment lit when all clear, flashing when some clear, dark when none.
// - After five seconds clear field, display returns to the operating mode.
module indicator_ctrl
  import indicator_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input wire logic aclk, // System clock, 50 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic awvalid, // Write address valid.
  output logic awready, // Write address ready.
  input wire logic [7:0] awaddr, // Write byte address.
  input wire logic wvalid, // Write data valid.
  output logic wready, // Write data ready.
  input wire logic [31:0] wdata, // Write data.
  input wire logic [3:0] wstrb, // Write byte strobes.
  output logic bvalid, // Write response valid.
  input wire logic bready, // Write response ready.
  output logic [1:0] bresp, // Write response code.
  input wire logic arvalid, // Read address valid.
  output logic arready, // Read address ready.
  input wire logic [7:0] araddr, // Read byte address.
  output logic rvalid, // Read data valid.
  input wire logic rready, // Read data ready.
  output logic [31:0] rdata, // Read data.
  output logic [1:0] rresp, // Read response code.
  output logic led_red, // Status LED red element.
  output logic led_green, // Status LED green element.
  output logic led_yellow, // Interlock LED.
  output logic led_blue, // Special function LED.
  output logic [6:0] seg, // Display segments g to a, high lit.
  output logic automatic_error_recovery, // One-cycle recovery pulse.
  output logic irq // Level interrupt.
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [12:0] state;
    logic [2:0] mode;
    logic [7:0] resp;
    logic [1:0] err_class;
    logic [7:0] err_code;
    logic err_block;
    logic [1:0] chg_left;
    logic [9:0] chg_cnt;
    logic [5:0] beams;
    logic [3:0] int_stat;
    logic [3:0] int_mask;
    logic [31:0] pre_cnt;
    logic tick;
    logic [9:0] blink_cnt;
    logic [5:0] fast_cnt;
    logic fast_ph;
    boot_t boot;
    logic [9:0] boot_cnt;
    logic [13:0] err_cnt;
    logic [1:0] err_step;
    logic [9:0] step_cnt;
    logic [12:0] int_cnt;
    logic [12:0] clr_cnt;
    logic align;
    logic led_red;
    logic led_green;
    logic led_yellow;
    logic led_blue;
    logic [6:0] seg;
    logic recov;
  } st_t;

  st_t s_r;
  st_t s_nxt;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : wmerge

  function automatic logic [6:0] digit_seg(input logic [3:0] d);
    case (d)
      4'h0: digit_seg = SEG_0;
      4'h1: digit_seg = SEG_1;
      4'h2: digit_seg = SEG_2;
      4'h3: digit_seg = SEG_3;
      4'h4: digit_seg = SEG_4;
      4'h5: digit_seg = SEG_5;
      4'h6: digit_seg = SEG_6;
      4'h7: digit_seg = SEG_7;
      4'h8: digit_seg = SEG_8;
      4'h9: digit_seg = SEG_9;
      default: digit_seg = SEG_OFF;
    endcase
  endfunction : digit_seg

  // Beam area pair is {all clear, any clear}.
  function automatic logic beam_seg(input logic [1:0] b, input logic ph);
    beam_seg = b[1] ? 1'b1 : (b[0] ? ph : 1'b0);
  endfunction : beam_seg

  // Half-turn rotation swaps a with d, b with e, c with f.
  function automatic logic [6:0] rot180(input logic [6:0] x);
    rot180 = {x[6], x[2], x[1], x[0], x[5], x[4], x[3]};
  endfunction : rot180

  // ---------------------------------------------------------------------------
  // Bus handshakes, combinational from state
  // ---------------------------------------------------------------------------
  assign awready = !s_r.aw_have && !s_r.bvalid;
  assign wready = !s_r.w_have && !s_r.bvalid;
  assign arready = !s_r.rvalid;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign rvalid = s_r.rvalid;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;
  assign led_red = s_r.led_red;
  assign led_green = s_r.led_green;
  assign led_yellow = s_r.led_yellow;
  assign led_blue = s_r.led_blue;
  assign seg = s_r.seg;
  assign automatic_error_recovery = s_r.recov;
  assign irq = |(s_r.int_stat & s_r.int_mask);

  logic aw_fire;
  logic w_fire;
  logic wr_go;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_be;
  logic [31:0] mg;
  logic [3:0] ev;
  logic [3:0] w1c;
  logic slow_on;
  logic short_on;
  logic st_f;
  logic st_e;
  logic [6:0] logic_seg;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    s_nxt.recov = 1'b0;
    ev = 4'h0;
    w1c = 4'h0;
    mg = 32'h0;
    logic_seg = SEG_OFF;
    aw_fire = awvalid && awready;
    w_fire = wvalid && wready;
    wr_addr = s_r.aw_have ? s_r.awaddr : awaddr;
    wr_data = s_r.w_have ? s_r.wdata : wdata;
    wr_be = s_r.w_have ? s_r.wstrb : wstrb;
    wr_go = (s_r.aw_have || aw_fire) && (s_r.w_have || w_fire);
    slow_on = s_r.blink_cnt < SLOW_ON_MS;
    short_on = s_r.blink_cnt < SHORT_ON_MS;
    st_f = s_r.err_class == CLASS_F;
    st_e = (s_r.err_class == CLASS_E) || (s_r.err_class == CLASS_U);

    // One prescaler feeds every flash rate and timer.
    if (s_r.pre_cnt == 32'(TICK_CYC - 1)) begin
      s_nxt.pre_cnt = 32'h0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.pre_cnt = s_r.pre_cnt + 32'h1;
    end
    if (s_r.tick) begin
      s_nxt.blink_cnt = (s_r.blink_cnt == SLOW_PERIOD_MS - 10'd1) ? 10'h0 : s_r.blink_cnt + 10'd1;
      if (s_r.fast_cnt == FAST_HALF_MS - 6'd1) begin
        s_nxt.fast_cnt = 6'h0;
        s_nxt.fast_ph = !s_r.fast_ph;
      end else begin
        s_nxt.fast_cnt = s_r.fast_cnt + 6'd1;
      end
    end

    // Power-up sequence: eight, then t, tens and ones, one step each.
    if (s_r.tick && s_r.boot != BOOT_DONE) begin
      if (s_r.boot_cnt == STEP_MS - 10'd1) begin
        s_nxt.boot_cnt = 10'h0;
        case (s_r.boot)
          BOOT_TEST: s_nxt.boot = BOOT_T;
          BOOT_T: s_nxt.boot = BOOT_TENS;
          BOOT_TENS: s_nxt.boot = BOOT_ONES;
          default: s_nxt.boot = BOOT_DONE;
        endcase
      end else begin
        s_nxt.boot_cnt = s_r.boot_cnt + 10'd1;
      end
    end

    // Error display cycle and automatic recovery of non-locking errors.
    if (s_r.tick && s_r.err_class != CLASS_NONE) begin
      if (s_r.step_cnt == STEP_MS - 10'd1) begin
        s_nxt.step_cnt = 10'h0;
        s_nxt.err_step = s_r.err_step + 2'd1;
      end else begin
        s_nxt.step_cnt = s_r.step_cnt + 10'd1;
      end
      // Recovery only clears the indication; the outputs still wait for a restart.
      if (!s_r.err_block) begin
        if (s_r.err_cnt == RECOVER_MS - 14'd1) begin
          s_nxt.err_class = CLASS_NONE;
          s_nxt.err_code = 8'h0;
          s_nxt.err_cnt = 14'h0;
          s_nxt.recov = 1'b1;
          ev[EV_RECOVERY] = 1'b1;
        end else begin
          s_nxt.err_cnt = s_r.err_cnt + 14'd1;
        end
      end
    end

    // Field timers; each saturates at the alignment threshold.
    if (s_r.state[ST_FIELD_CLEAR]) begin
      s_nxt.int_cnt = 13'h0;
      if (s_r.tick && s_r.clr_cnt < ALIGN_MS) begin
        s_nxt.clr_cnt = s_r.clr_cnt + 13'd1;
      end
    end else begin
      s_nxt.clr_cnt = 13'h0;
      if (s_r.tick && s_r.int_cnt < ALIGN_MS) begin
        s_nxt.int_cnt = s_r.int_cnt + 13'd1;
      end
    end
    if (!s_r.state[ST_ALIGNED] || s_r.int_cnt >= ALIGN_MS) begin
      s_nxt.align = 1'b1;
    end else if (s_r.clr_cnt >= ALIGN_MS) begin
      s_nxt.align = 1'b0;
    end
    ev[EV_ALIGN_IN] = s_nxt.align && !s_r.align;
    ev[EV_ALIGN_OUT] = !s_nxt.align && s_r.align;

    // Changeover flashes count down one per period.
    if (s_r.tick && s_r.chg_left != 2'h0) begin
      if (s_r.chg_cnt == CHG_PERIOD_MS - 10'd1) begin
        s_nxt.chg_cnt = 10'h0;
        s_nxt.chg_left = s_r.chg_left - 2'd1;
      end else begin
        s_nxt.chg_cnt = s_r.chg_cnt + 10'd1;
      end
    end

    // Write channel: address and data are taken in either order.
    if (aw_fire && !wr_go) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.awaddr = awaddr;
    end
    if (w_fire && !wr_go) begin
      s_nxt.w_have = 1'b1;
      s_nxt.wdata = wdata;
      s_nxt.wstrb = wstrb;
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr_go) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = 2'b00;
      case (wr_addr)
        OFS_STATE: begin
          mg = wmerge({19'h0, s_r.state}, wr_data, wr_be);
          s_nxt.state = mg[12:0];
        end
        OFS_MODE: begin
          mg = wmerge({29'h0, s_r.mode}, wr_data, wr_be);
          // Mode values outside one to six are ignored.
          if (mg[2:0] >= 3'd1 && mg[2:0] <= 3'd6) begin
            s_nxt.mode = mg[2:0];
          end
        end
        OFS_RESP: begin
          mg = wmerge({24'h0, s_r.resp}, wr_data, wr_be);
          s_nxt.resp = mg[7:0];
        end
        OFS_ERROR: begin
          mg = wmerge({19'h0, s_r.err_block, s_r.err_code, 2'h0, s_r.err_class}, wr_data, wr_be);
          // A latched blocking error ignores software; only reset clears it.
          if (!s_r.err_block) begin
            s_nxt.err_class = mg[1:0];
            s_nxt.err_code = mg[11:4];
            s_nxt.err_block = mg[12] && (mg[1:0] != CLASS_NONE);
            s_nxt.err_cnt = 14'h0;
            s_nxt.err_step = 2'h0;
            s_nxt.step_cnt = 10'h0;
            ev[EV_ERROR] = mg[1:0] != CLASS_NONE;
          end
        end
        OFS_CHANGE: begin
          if (wr_be[0] && wr_data[1:0] != 2'h0) begin
            s_nxt.chg_left = (wr_data[1:0] == 2'h3) ? 2'h2 : wr_data[1:0];
            s_nxt.chg_cnt = 10'h0;
          end
        end
        OFS_BEAMS: begin
          mg = wmerge({26'h0, s_r.beams}, wr_data, wr_be);
          s_nxt.beams = mg[5:0];
        end
        OFS_INT_STAT: w1c = wr_be[0] ? wr_data[3:0] : 4'h0;
        OFS_INT_MASK: begin
          mg = wmerge({28'h0, s_r.int_mask}, wr_data, wr_be);
          s_nxt.int_mask = mg[3:0];
        end
        OFS_INDIC: s_nxt.bresp = 2'b00;
        default: s_nxt.bresp = 2'b10;
      endcase
    end
    // A new event wins over a clear in the same cycle.
    s_nxt.int_stat = (s_r.int_stat & ~w1c) | ev;

    // Read channel.
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = 2'b00;
      case (araddr)
        OFS_STATE: s_nxt.rdata = {19'h0, s_r.state};
        OFS_MODE: s_nxt.rdata = {29'h0, s_r.mode};
        OFS_RESP: s_nxt.rdata = {24'h0, s_r.resp};
        OFS_ERROR: s_nxt.rdata = {19'h0, s_r.err_block, s_r.err_code, 2'h0, s_r.err_class};
        OFS_CHANGE: s_nxt.rdata = {30'h0, s_r.chg_left};
        OFS_BEAMS: s_nxt.rdata = {26'h0, s_r.beams};
        OFS_INDIC: s_nxt.rdata = {19'h0, s_r.seg, s_r.led_red, s_r.led_green, s_r.led_yellow,
                                  s_r.led_blue, s_r.align, s_r.boot == BOOT_DONE};
        OFS_INT_STAT: s_nxt.rdata = {28'h0, s_r.int_stat};
        OFS_INT_MASK: s_nxt.rdata = {28'h0, s_r.int_mask};
        default: begin
          s_nxt.rdata = 32'h0;
          s_nxt.rresp = 2'b10;
        end
      endcase
    end

    // Status LED: internal error over external error over output state.
    s_nxt.led_red = 1'b0;
    s_nxt.led_green = 1'b0;
    if (st_f) begin
      s_nxt.led_red = s_r.fast_ph;
    end else if (st_e) begin
      s_nxt.led_red = slow_on;
    end else if (!s_r.state[ST_SAFE_ON]) begin
      s_nxt.led_red = 1'b1;
    end else begin
      s_nxt.led_green = s_r.state[ST_WEAK] ? slow_on : 1'b1;
    end

    // Interlock LED.
    if (s_r.state[ST_UPSTREAM_OPEN]) begin
      s_nxt.led_yellow = slow_on;
    end else if (s_r.chg_left != 2'h0) begin
      s_nxt.led_yellow = s_r.chg_cnt < CHG_ON_MS;
    end else begin
      s_nxt.led_yellow = s_r.state[ST_RI_ACTIVE] && s_r.state[ST_RI_LOCKED] &&
                         s_r.state[ST_FIELD_CLEAR] && s_r.state[ST_LINKED_OK];
    end

    // Special function LED.
    if (s_r.state[ST_TEACH] || s_r.state[ST_MUTE_RESTART] || s_r.state[ST_OVERRIDE]) begin
      s_nxt.led_blue = short_on;
    end else if (s_r.state[ST_MUTING]) begin
      s_nxt.led_blue = slow_on;
    end else begin
      s_nxt.led_blue = s_r.state[ST_TAUGHT];
    end

    // Display content by priority: power-up, error, alignment, mode.
    case (s_r.boot)
      BOOT_TEST: logic_seg = SEG_8;
      BOOT_T: logic_seg = SEG_T;
      BOOT_TENS: logic_seg = digit_seg(s_r.resp[7:4]);
      BOOT_ONES: logic_seg = digit_seg(s_r.resp[3:0]);
      default: begin
        if (s_r.err_class != CLASS_NONE) begin
          case (s_r.err_step)
            2'd0: logic_seg = st_f ? SEG_F : (s_r.err_class == CLASS_E ? SEG_E : SEG_U);
            2'd1: logic_seg = digit_seg(s_r.err_code[7:4]);
            2'd2: logic_seg = digit_seg(s_r.err_code[3:0]);
            default: logic_seg = SEG_OFF;
          endcase
        end else if (s_r.align) begin
          logic_seg = {beam_seg(s_r.beams[3:2], slow_on), 2'b00,
                       beam_seg(s_r.beams[1:0], slow_on), 2'b00,
                       beam_seg(s_r.beams[5:4], slow_on)};
        end else begin
          logic_seg = digit_seg({1'b0, s_r.mode});
        end
      end
    endcase
    s_nxt.seg = (s_r.mode == 3'd4 || s_r.mode == 3'd6) ? rot180(logic_seg) : logic_seg;
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.mode <= MODE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_int_err;
    st_f ##1 st_f;
  endsequence

  a_int_err_fast: assert property (seq_int_err |-> led_red == $past(s_r.fast_ph) && !led_green)
    else $error("Internal error does not flash red fast.");
  a_ext_err_slow: assert property (st_e && $past(st_e) |-> !led_green &&
    led_red == ($past(s_r.blink_cnt) < SLOW_ON_MS))
    else $error("External error does not flash red slowly.");
  a_green_solid: assert property (s_r.err_class == CLASS_NONE && s_r.state[ST_SAFE_ON] &&
    !s_r.state[ST_WEAK] |=> led_green && !led_red)
    else $error("Green not solid while outputs are on.");
  a_yellow_ready: assert property (!s_r.state[ST_UPSTREAM_OPEN] && s_r.chg_left == 2'h0 &&
    !s_r.state[ST_FIELD_CLEAR] |=> !led_yellow)
    else $error("Yellow lit while the field is interrupted.");
  a_blue_short: assert property ($past(s_r.state[ST_TEACH]) && led_blue |->
    $past(s_r.blink_cnt) < SHORT_ON_MS)
    else $error("Blue short flash too long.");
  a_block_lock: assert property (s_r.err_block |=> s_r.err_block &&
    $stable(s_r.err_class) && !automatic_error_recovery)
    else $error("Blocking error released without reset.");
  a_recover_time: assert property (automatic_error_recovery |->
    $past(s_r.err_cnt) == RECOVER_MS - 14'd1 && !$past(s_r.err_block) &&
    s_r.err_class == CLASS_NONE)
    else $error("Recovery at wrong time.");
  a_align_enter: assert property ($rose(s_r.align) |->
    !$past(s_r.state[ST_ALIGNED]) || $past(s_r.int_cnt) >= ALIGN_MS)
    else $error("Alignment entered too early.");
  a_align_leave: assert property ($fell(s_r.align) |-> $past(s_r.clr_cnt) >= ALIGN_MS)
    else $error("Alignment left too early.");
  a_boot_eight: assert property (s_r.boot == BOOT_TEST ##1 s_r.boot == BOOT_TEST |->
    seg == SEG_8)
    else $error("Self test digit not shown.");

endmodule : indicator_ctrl

// file: hdl/indicator_pkg.sv
package indicator_pkg;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_STATE = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_RESP = 8'h08;
  localparam logic [7:0] OFS_ERROR = 8'h0c;
  localparam logic [7:0] OFS_CHANGE = 8'h10;
  localparam logic [7:0] OFS_BEAMS = 8'h14;
  localparam logic [7:0] OFS_INDIC = 8'h18;
  localparam logic [7:0] OFS_INT_STAT = 8'h1c;
  localparam logic [7:0] OFS_INT_MASK = 8'h20;

  // ---------------------------------------------------------------------------
  // Field positions of the state register
  // ---------------------------------------------------------------------------
  localparam int ST_SAFE_ON = 0;
  localparam int ST_WEAK = 1;
  localparam int ST_RI_ACTIVE = 2;
  localparam int ST_RI_LOCKED = 3;
  localparam int ST_FIELD_CLEAR = 4;
  localparam int ST_LINKED_OK = 5;
  localparam int ST_UPSTREAM_OPEN = 6;
  localparam int ST_TAUGHT = 7;
  localparam int ST_MUTING = 8;
  localparam int ST_TEACH = 9;
  localparam int ST_MUTE_RESTART = 10;
  localparam int ST_OVERRIDE = 11;
  localparam int ST_ALIGNED = 12;

  // Interrupt bits: recovery, alignment entered, alignment left, error latched.
  localparam int EV_RECOVERY = 0;
  localparam int EV_ALIGN_IN = 1;
  localparam int EV_ALIGN_OUT = 2;
  localparam int EV_ERROR = 3;

  // ---------------------------------------------------------------------------
  // Reset values and error classes
  // ---------------------------------------------------------------------------
  localparam logic [2:0] MODE_RST = 3'h1;
  localparam logic [1:0] CLASS_NONE = 2'h0;
  localparam logic [1:0] CLASS_F = 2'h1;
  localparam logic [1:0] CLASS_E = 2'h2;
  localparam logic [1:0] CLASS_U = 2'h3;

  // ---------------------------------------------------------------------------
  // Timing: one prescaler tick of 1 ms, all indicator timers count ticks
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam logic [9:0] SLOW_PERIOD_MS = 10'd1000;
  localparam logic [9:0] SLOW_ON_MS = 10'd500;
  localparam logic [9:0] SHORT_ON_MS = 10'd100;
  localparam logic [5:0] FAST_HALF_MS = 6'd50;
  localparam logic [9:0] STEP_MS = 10'd1000;
  localparam logic [9:0] CHG_PERIOD_MS = 10'd500;
  localparam logic [9:0] CHG_ON_MS = 10'd250;
  localparam logic [12:0] ALIGN_MS = 13'd5000;
  localparam logic [13:0] RECOVER_MS = 14'd10000;

  // ---------------------------------------------------------------------------
  // Segment patterns, bit order g f e d c b a
  // ---------------------------------------------------------------------------
  localparam logic [6:0] SEG_0 = 7'h3f;
  localparam logic [6:0] SEG_1 = 7'h06;
  localparam logic [6:0] SEG_2 = 7'h5b;
  localparam logic [6:0] SEG_3 = 7'h4f;
  localparam logic [6:0] SEG_4 = 7'h66;
  localparam logic [6:0] SEG_5 = 7'h6d;
  localparam logic [6:0] SEG_6 = 7'h7d;
  localparam logic [6:0] SEG_7 = 7'h07;
  localparam logic [6:0] SEG_8 = 7'h7f;
  localparam logic [6:0] SEG_9 = 7'h6f;
  localparam logic [6:0] SEG_T = 7'h78;
  localparam logic [6:0] SEG_F = 7'h71;
  localparam logic [6:0] SEG_E = 7'h79;
  localparam logic [6:0] SEG_U = 7'h3e;
  localparam logic [6:0] SEG_OFF = 7'h00;

  typedef enum logic [2:0] {BOOT_TEST, BOOT_T, BOOT_TENS, BOOT_ONES, BOOT_DONE} boot_t;

endpackage : indicator_pkg
